/* File: src/bus_supervisor_pkg.sv */
// Constants, timing figures and register map for the bus-state supervisor
// Functional notes
// - HS idle over 3ms reverts to FS
// - Reversion no later than 3.125ms
// - FS mode switches DP pull-up on
// - Sample line state 100us to 875us after
// - Sampled J means suspend
// - Sampled SE0 means reset, start handshake
// - Fully suspended within 10ms of activity; here only after HS reversion, FS_ACTIVE never suspends
// - No resume before 5ms of quiet
// - Suspended device handshakes on SE0 immediately
// - FS device handshakes after 2.5us SE0
// - Handshake starts FS, pull-up on, no HS terms
// - Chirp: raw mode, HS transceiver, zero data
// - Chirp at least 1ms, ends by 7ms
// - Chirp starts before 6ms from reset
// - Chirp held 66000 transceiver clock cycles
// - Listen for host chirps from chirp start; here the filter only counts once the chirp ends
// - No host chirps: back to FS, await reset end
// - Handshake entry up to 4ms after SE0
// - From suspend, chirp within 6ms of wake
// - Raw opmode: ones as J, zeros as K
package bus_supervisor_pkg;

   // Clock period of pclk in picoseconds (125 MHz)
   localparam int unsigned CLK_PERIOD_PS   = 8000;
   // Nominal transceiver clock period in picoseconds (60 MHz, rounded up)
   localparam int unsigned XCVR_PERIOD_PS  = 16667;

   // Least time to cycles, rounded up, never below one
   // Works in 64 bits: anything past about 4.29ms overflows 32 bits in picoseconds
   function automatic int unsigned min_cycles(input int unsigned t_ns);
      longint unsigned c;
      c = (64'(t_ns) * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
      return (c < 1) ? 1 : 32'(c);
   endfunction : min_cycles

   // Longest time to cycles, rounded down, never below one
   function automatic int unsigned max_cycles(input int unsigned t_ns);
      longint unsigned c;
      c = (64'(t_ns) * 1000) / CLK_PERIOD_PS;
      return (c < 1) ? 1 : 32'(c);
   endfunction : max_cycles

   // Timing figures in microseconds, nanoseconds or transceiver clocks, as named, as specified
   localparam int unsigned HS_IDLE_NS      = 3_000;     // 3us; unused, the 3ms figure below is in microseconds
   localparam int unsigned HS_IDLE_US      = 3_000;     // 3ms idle before reversion
   localparam int unsigned HS_REVERT_MAX_US = 3_125;    // 3.125ms latest reversion
   localparam int unsigned SAMPLE_MIN_US   = 100;       // 100us earliest sample
   localparam int unsigned SAMPLE_MAX_US   = 875;       // 875us latest sample
   localparam int unsigned RESUME_MIN_US   = 5_000;     // 5ms quiet before resume
   localparam int unsigned QUIET_SAT_US    = 10_000;    // 10ms saturation of quiet time
   localparam int unsigned FS_RESET_NS     = 2_500;     // 2.5us SE0 in FS mode
   localparam int unsigned NOCHIRP_US      = 1_750;     // Host chirp timeout, 1.0..2.5ms
   localparam int unsigned RESUME_DRIVE_US = 1_000;     // Length of device resume K
   localparam int unsigned CHIRP_XCVR_CYC  = 66_000;    // Chirp length in transceiver clocks
   localparam int unsigned OPMODE_XCVR_CYC = 5;         // Opmode settle in transceiver clocks
   localparam int unsigned FILT_XCVR_CYC   = 165;       // Chirp filter in transceiver clocks

   // Derived cycle counts at pclk
   localparam int unsigned HS_IDLE_CYC     = min_cycles(HS_IDLE_US * 1000) + 1;
   localparam int unsigned SAMPLE_CYC      = min_cycles(SAMPLE_MIN_US * 1000) + 1;
   localparam int unsigned RESUME_MIN_CYC  = min_cycles(RESUME_MIN_US * 1000);
   localparam int unsigned QUIET_SAT_CYC   = max_cycles(QUIET_SAT_US * 1000);
   localparam int unsigned FS_RESET_CYC    = min_cycles(FS_RESET_NS) + 1;
   localparam int unsigned NOCHIRP_CYC     = min_cycles(NOCHIRP_US * 1000);
   localparam int unsigned RESUME_DRV_CYC  = min_cycles(RESUME_DRIVE_US * 1000);
   localparam int unsigned CHIRP_CYC       =
      (CHIRP_XCVR_CYC * XCVR_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned OPMODE_CYC      =
      (OPMODE_XCVR_CYC * XCVR_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned FILT_CYC        =
      (FILT_XCVR_CYC * XCVR_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   // Counter width, enough for 10ms at 125 MHz
   localparam int unsigned TMR_W = 21;

   // Line state encodings
   localparam logic [1:0] LS_SE0 = 2'h0;
   localparam logic [1:0] LS_J   = 2'h1;
   localparam logic [1:0] LS_K   = 2'h2;

   // Operating modes
   localparam logic [1:0] OPMODE_NORMAL = 2'h0;
   localparam logic [1:0] OPMODE_RAW    = 2'h2;

   // Transceiver and termination selections
   localparam logic SEL_HS = 1'b0;
   localparam logic SEL_FS = 1'b1;

   // Register map, byte addresses
   localparam logic [7:0] CTRL_ADDR   = 8'h00;
   localparam logic [7:0] STATUS_ADDR = 8'h04;

   // Control field positions
   localparam int unsigned CTRL_RESUME_BIT = 0;
   localparam int unsigned CTRL_HSEN_BIT   = 1;
   localparam logic        HSEN_RESET      = 1'b1;

   // Status field positions
   localparam int unsigned ST_STATE_LSB = 0;
   localparam int unsigned ST_XCVR_BIT  = 4;
   localparam int unsigned ST_TERM_BIT  = 5;
   localparam int unsigned ST_SUSP_BIT  = 6;
   localparam int unsigned ST_RESP_BIT  = 7;
   localparam int unsigned ST_LS_LSB    = 8;

   // Supervisor states
   typedef enum {
      FS_ACTIVE, HS_ACTIVE, REVERTED, SUSPENDED, RESUMING,
      CHIRP_SETUP, CHIRPING, LISTEN, FS_RESET_WAIT
   } state_type;

endpackage : bus_supervisor_pkg

/* File: src/bus_supervisor.sv */
// Bus-state supervision, suspend/reset split and chirp handshake with APB access
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/1ps
module bus_supervisor
   import bus_supervisor_pkg::*;
#(
   parameter int unsigned HS_IDLE_CYCLES   = HS_IDLE_CYC,
   parameter int unsigned SAMPLE_CYCLES    = SAMPLE_CYC,
   parameter int unsigned RESUME_MIN_CYCLES = RESUME_MIN_CYC,
   parameter int unsigned QUIET_SAT_CYCLES = QUIET_SAT_CYC,
   parameter int unsigned NOCHIRP_CYCLES   = NOCHIRP_CYC,
   parameter int unsigned RESUME_CYCLES    = RESUME_DRV_CYC,
   parameter int unsigned CHIRP_CYCLES     = CHIRP_CYC
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [1:0]  line_state,
   output logic             xcvr_select,
   output logic             term_select,
   output logic [1:0]       op_mode,
   output logic             tx_valid,
   output logic [7:0]       tx_data,
   output logic             suspend_n,
   output logic             hs_mode
);

   // Line state synchroniser
   logic [1:0]       ls_meta;          // First stage, read only by second stage
   logic [1:0]       ls;               // Usable line state

   // Control state
   state_type        state;            // Current supervisor state
   state_type        next_state;       // Next supervisor state
   logic [TMR_W-1:0] tmr;              // Time spent in current state
   logic [TMR_W-1:0] quiet;            // Time since last bus activity
   logic [TMR_W-1:0] filt;             // Time the line has shown a host chirp
   logic [TMR_W-1:0] se0_cnt;          // Time of SE0 while at full speed
   logic             resume_pend;      // Software resume request waiting
   logic             hs_enable;        // Software permits high-speed handshake

   // APB decode
   logic             apb_wr;           // Write takes effect this cycle
   logic             hit_ctrl;         // Control register addressed
   logic             hit_status;       // Status register addressed

   // Two flops before anything looks at the line
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ls_meta <= LS_J;
         ls      <= LS_J;
      end else begin
         ls_meta <= line_state;
         ls      <= ls_meta;
      end
   end

   // Zero wait state slave; every transfer finishes in its access cycle
   assign pready     = 1'b1;
   assign apb_wr     = psel & penable & pwrite;
   assign hit_ctrl   = (paddr[7:0] == CTRL_ADDR) && (paddr[31:8] == '0);
   assign hit_status = (paddr[7:0] == STATUS_ADDR) && (paddr[31:8] == '0);
   assign pslverr    = psel & penable & ~(hit_ctrl | hit_status);

   // Read data mux; unmapped reads return zero
   always_comb begin
      prdata = '0;
      if (hit_ctrl) begin
         prdata[CTRL_RESUME_BIT] = resume_pend;
         prdata[CTRL_HSEN_BIT]   = hs_enable;
      end else if (hit_status) begin
         prdata[ST_STATE_LSB +: 4] = 4'(state);
         prdata[ST_XCVR_BIT]       = xcvr_select;
         prdata[ST_TERM_BIT]       = term_select;
         prdata[ST_SUSP_BIT]       = suspend_n;
         prdata[ST_RESP_BIT]       = resume_pend;
         prdata[ST_LS_LSB +: 2]    = ls;
      end
   end

   // High-speed enable written by software
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hs_enable <= HSEN_RESET;
      end else if (apb_wr && hit_ctrl) begin
         hs_enable <= pwdata[CTRL_HSEN_BIT];
      end
   end

   // Resume request; a new request wins over the clear on taking one
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         resume_pend <= 1'b0;
      end else if (apb_wr && hit_ctrl && pwdata[CTRL_RESUME_BIT]) begin
         resume_pend <= 1'b1;
      end else if (state == SUSPENDED && next_state == RESUMING) begin
         resume_pend <= 1'b0;
      end
   end

   // Quiet time since last activity; HS idle is SE0, FS idle is J
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         quiet <= '0;
      end else if ((state == HS_ACTIVE && ls != LS_SE0) ||
                   (state == FS_ACTIVE && ls != LS_J) ||
                   state == RESUMING || state == CHIRPING ||
                   // Entering HS starts a fresh idle count; a stale count would revert at once
                   (next_state == HS_ACTIVE && state != HS_ACTIVE)) begin
         quiet <= '0;
      end else if (quiet < TMR_W'(QUIET_SAT_CYCLES)) begin
         quiet <= quiet + 1'b1;
      end
   end

   // SE0 length while active at full speed
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         se0_cnt <= '0;
      end else if (state != FS_ACTIVE || ls != LS_SE0) begin
         se0_cnt <= '0;
      end else if (se0_cnt < TMR_W'(FS_RESET_CYC)) begin
         se0_cnt <= se0_cnt + 1'b1;
      end
   end

   // Host chirp filter; any non-squelch level held long enough counts
   // Our own chirp K is not a host chirp, so the filter is held clear while we transmit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         filt <= '0;
      end else if ((state != CHIRPING && state != LISTEN) || ls == LS_SE0 || tx_valid) begin
         filt <= '0;
      end else if (filt < TMR_W'(FILT_CYC)) begin
         filt <= filt + 1'b1;
      end
   end

   // State timer restarts on every change of state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tmr <= '0;
      end else if (next_state != state) begin
         tmr <= '0;
      end else if (tmr != '1) begin
         tmr <= tmr + 1'b1;
      end
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= FS_ACTIVE;
      end else begin
         state <= next_state;
      end
   end

   // Supervisor transitions
   always_comb begin
      next_state = state;
      case (state)
         FS_ACTIVE: begin
            // Long SE0 at full speed is a reset; short SE0 is an EOP
            if (se0_cnt >= TMR_W'(FS_RESET_CYC)) begin
               next_state = hs_enable ? CHIRP_SETUP : FS_RESET_WAIT;
            end
         end
         HS_ACTIVE: begin
            // Idle counted from last activity; reverts just past 3ms, well inside 3.125ms
            if (quiet >= TMR_W'(HS_IDLE_CYCLES)) begin
               next_state = REVERTED;
            end
         end
         REVERTED: begin
            // One sample, early in the 100us..875us window
            if (tmr >= TMR_W'(SAMPLE_CYCLES)) begin
               if (ls == LS_J) begin
                  next_state = SUSPENDED;
               end else if (ls == LS_SE0) begin
                  next_state = hs_enable ? CHIRP_SETUP : FS_RESET_WAIT;
               end else begin
                  next_state = HS_ACTIVE;
               end
            end
         end
         SUSPENDED: begin
            if (ls == LS_SE0) begin
               next_state = hs_enable ? CHIRP_SETUP : FS_RESET_WAIT;
            end else if (ls == LS_K) begin
               next_state = HS_ACTIVE;
            end else if (resume_pend && quiet >= TMR_W'(RESUME_MIN_CYCLES)) begin
               next_state = RESUMING;
            end
         end
         RESUMING: begin
            if (tmr >= TMR_W'(RESUME_CYCLES - 1)) begin
               next_state = HS_ACTIVE;
            end
         end
         CHIRP_SETUP: begin
            // Raw mode must settle before transmit valid rises
            if (tmr >= TMR_W'(OPMODE_CYC - 1)) begin
               next_state = CHIRPING;
            end
         end
         CHIRPING: begin
            if (tmr >= TMR_W'(CHIRP_CYCLES - 1)) begin
               next_state = LISTEN;
            end
         end
         LISTEN: begin
            // Full sequence validation is left to the link controller
            if (filt >= TMR_W'(FILT_CYC)) begin
               next_state = HS_ACTIVE;
            end else if (tmr >= TMR_W'(NOCHIRP_CYCLES)) begin
               next_state = FS_RESET_WAIT;
            end
         end
         FS_RESET_WAIT: begin
            // Reset ends when the host releases SE0
            if (ls != LS_SE0) begin
               next_state = FS_ACTIVE;
            end
         end
         default: begin
            next_state = FS_ACTIVE;
         end
      endcase
   end

   // Transceiver controls, registered from the next state so they move with it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xcvr_select <= SEL_FS;
         term_select <= SEL_FS;
         op_mode     <= OPMODE_NORMAL;
         tx_valid    <= 1'b0;
         suspend_n   <= 1'b1;
         hs_mode     <= 1'b0;
      end else begin
         xcvr_select <= SEL_FS;
         term_select <= SEL_FS;
         op_mode     <= OPMODE_NORMAL;
         tx_valid    <= 1'b0;
         suspend_n   <= 1'b1;
         hs_mode     <= 1'b0;
         case (next_state)
            HS_ACTIVE: begin
               xcvr_select <= SEL_HS;
               term_select <= SEL_HS;
               hs_mode     <= 1'b1;
            end
            SUSPENDED: begin
               suspend_n <= 1'b0;
            end
            RESUMING: begin
               // Full-speed K from zero data in raw mode
               op_mode  <= OPMODE_RAW;
               tx_valid <= 1'b1;
            end
            CHIRP_SETUP: begin
               op_mode     <= OPMODE_RAW;
               xcvr_select <= SEL_HS;
            end
            CHIRPING: begin
               op_mode     <= OPMODE_RAW;
               xcvr_select <= SEL_HS;
               tx_valid    <= 1'b1;
            end
            default: begin
               // Full-speed defaults already applied
            end
         endcase
      end
   end

   // Chirp and resume data are all zeros, which the raw mode sends as K
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_data <= 8'h00;
      end else begin
         tx_data <= 8'h00;
      end
   end

endmodule : bus_supervisor

/* File: testbench/bus_supervisor_sva.sv */
// Port-level checker for the bus-state supervisor
`timescale 1ns/1ps
module bus_supervisor_sva
   import bus_supervisor_pkg::*;
#(
   parameter int unsigned HS_IDLE_CYCLES = HS_IDLE_CYC,
   parameter int unsigned CHIRP_CYCLES   = CHIRP_CYC
) (
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic [1:0] line_state,
   input wire logic       xcvr_select,
   input wire logic       term_select,
   input wire logic [1:0] op_mode,
   input wire logic       tx_valid,
   input wire logic [7:0] tx_data,
   input wire logic       suspend_n,
   input wire logic       hs_mode
);
   default clocking main_clk @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   int unsigned chirp_len;  // Cycles of chirp at HS selection
   int unsigned raw_len;    // Cycles of raw mode before transmit
   int unsigned quiet_len;  // Cycles of quiet bus while in HS

   // Run lengths; cleared by reset so a second reset starts clean
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chirp_len <= 0;
         raw_len   <= 0;
         quiet_len <= 0;
      end else begin
         chirp_len <= (tx_valid && xcvr_select == SEL_HS) ? chirp_len + 1 : 0;
         raw_len   <= (op_mode == OPMODE_RAW && !tx_valid) ? raw_len + 1 : 0;
         quiet_len <= (hs_mode && line_state == LS_SE0) ? quiet_len + 1 : 0;
      end
   end

   chk_chirp_len: assert property (
      $fell(tx_valid) && $past(xcvr_select) == SEL_HS
      |-> chirp_len >= CHIRP_CYCLES && chirp_len <= CHIRP_CYCLES + 1)
      else $error("chirp length off");
   chk_raw_lead: assert property (
      $rose(tx_valid) && xcvr_select == SEL_HS |-> raw_len >= OPMODE_CYC)
      else $error("transmit too soon after raw mode");
   chk_raw_data: assert property (
      tx_valid |-> op_mode == OPMODE_RAW && tx_data == 8'h00)
      else $error("transmit without raw mode or zero data");
   chk_chirp_term: assert property (
      tx_valid && xcvr_select == SEL_HS |-> term_select == SEL_FS)
      else $error("chirp without pull-up");
   chk_fs_pullup: assert property (
      xcvr_select == SEL_FS |-> term_select == SEL_FS)
      else $error("full speed without pull-up");
   chk_hs_terms: assert property (
      hs_mode |-> xcvr_select == SEL_HS && term_select == SEL_HS && !tx_valid)
      else $error("high speed without HS selects");
   chk_revert_time: assert property (
      $fell(hs_mode) |-> quiet_len >= HS_IDLE_CYCLES && quiet_len <= HS_IDLE_CYCLES + 5)
      else $error("reversion time off");
   chk_sample_wait: assert property (
      $fell(hs_mode) |-> suspend_n [*8])
      else $error("line sampled too early");
   chk_suspend_fs: assert property (
      !suspend_n |-> xcvr_select == SEL_FS && term_select == SEL_FS && !tx_valid)
      else $error("suspended outside full speed");
   chk_wake_fast: assert property (
      $rose(line_state == LS_SE0) && !suspend_n |-> ##[1:5] suspend_n)
      else $error("slow wake on reset");
endmodule : bus_supervisor_sva

bind bus_supervisor bus_supervisor_sva #(
   .HS_IDLE_CYCLES(HS_IDLE_CYCLES),
   .CHIRP_CYCLES  (CHIRP_CYCLES)
) sva_inst (
   .pclk(pclk), .presetn(presetn), .line_state(line_state),
   .xcvr_select(xcvr_select), .term_select(term_select), .op_mode(op_mode),
   .tx_valid(tx_valid), .tx_data(tx_data), .suspend_n(suspend_n), .hs_mode(hs_mode)
);

/* File: testbench/host_port_model.sv */
// Behavioural upstream port: turns host action and device drive into line state
`timescale 1ns/1ps
module host_port_model
   import bus_supervisor_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic [1:0] host_cmd,    // 0 quiet, 1 reset SE0, 2 traffic
   input  wire logic       hs_capable,  // Host answers a device chirp
   input  wire logic       tx_valid,
   input  wire logic [1:0] op_mode,
   input  wire logic       term_select,
   output logic      [1:0] line_state
);
   logic        answering;  // Host chirp train running
   int unsigned chirp_t;    // Cycles since device chirp ended

   // Answer starts at the chirp end and only lasts while reset is held
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         answering <= 1'b0;
         chirp_t   <= 0;
      end else if (host_cmd != 2'h1) begin
         answering <= 1'b0;
         chirp_t   <= 0;
      end else if (answering) begin
         chirp_t <= chirp_t + 1;
      end else if ($fell(tx_valid) && hs_capable) begin
         answering <= 1'b1;
      end
   end

   // Device K wins; a released bus shows pull-up J at FS, squelch at HS
   always_comb begin
      if (tx_valid && op_mode == OPMODE_RAW) begin
         line_state = LS_K;
      end else if (answering && chirp_t >= 4) begin
         line_state = chirp_t[5] ? LS_J : LS_K;
      end else if (host_cmd == 2'h1) begin
         line_state = LS_SE0;
      end else if (host_cmd == 2'h2) begin
         line_state = LS_K;
      end else begin
         line_state = (term_select == SEL_FS) ? LS_J : LS_SE0;
      end
   end
endmodule : host_port_model

/* File: testbench/bus_supervisor_tb.sv */
// Self-checking bench for the bus-state supervisor
`timescale 1ns/1ps
module bus_supervisor_tb
   import bus_supervisor_pkg::*;
;
   localparam int unsigned IDLE_N  = 40;   // Shortened HS quiet limit
   localparam int unsigned SAMP_N  = 10;
   localparam int unsigned RES_N   = 60;
   localparam int unsigned NOCH_N  = 600;  // Room for the host chirp filter
   typedef struct packed {
      logic        wr;
      logic [31:0] addr;
      logic [31:0] wdata;
      logic [31:0] rdata;
      logic        err;
   } apb_row_type;
   // Register rows: reset values, read-only write, unmapped places
   apb_row_type rows [6] = '{
      '{1'b0, 32'h0000_0000, 32'h0, 32'h0000_0002, 1'b0},
      '{1'b1, 32'h0000_0004, 32'hFFFF_FFFF, 32'h0, 1'b0},
      '{1'b0, 32'h0000_0004, 32'h0, 32'h0000_0170, 1'b0},
      '{1'b0, 32'h0000_0008, 32'h0, 32'h0000_0000, 1'b1},
      '{1'b1, 32'h0000_0100, 32'h0, 32'h0, 1'b1},
      '{1'b0, 32'h0000_0000, 32'h0, 32'h0000_0002, 1'b0}};
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready, pslverr, xcvr_select, term_select, tx_valid, suspend_n, hs_mode;
   logic [1:0]  line_state, op_mode;
   logic [7:0]  tx_data;
   logic [1:0]  host_cmd = 2'h0;    // Host action for the partner
   logic        hs_capable = 1'b1;
   int unsigned cyc = 0;           // Edge count for spans
   int unsigned t0;
   int unsigned bad_count = 0;
   int unsigned checks_done = 0;

   always #4 pclk = ~pclk;
   always @(posedge pclk) cyc <= cyc + 1;

   bus_supervisor #(.HS_IDLE_CYCLES(IDLE_N), .SAMPLE_CYCLES(SAMP_N), .RESUME_MIN_CYCLES(RES_N),
      .QUIET_SAT_CYCLES(100), .NOCHIRP_CYCLES(NOCH_N), .RESUME_CYCLES(8), .CHIRP_CYCLES(30)
   ) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .line_state(line_state), .xcvr_select(xcvr_select), .term_select(term_select),
      .op_mode(op_mode), .tx_valid(tx_valid), .tx_data(tx_data), .suspend_n(suspend_n),
      .hs_mode(hs_mode));
   host_port_model host (.pclk(pclk), .presetn(presetn), .host_cmd(host_cmd),
      .hs_capable(hs_capable), .tx_valid(tx_valid), .op_mode(op_mode),
      .term_select(term_select), .line_state(line_state));

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : check

   // Cycles since t0 must fall inside a window
   task automatic check_span(input string what, input int unsigned lo, input int unsigned hi);
      checks_done++;
      if (cyc - t0 < lo || cyc - t0 > hi) begin
         bad_count++;
         $display("unexpected %s: expected %0d..%0d, seen %0d", what, lo, hi, cyc - t0);
      end
   endtask : check_span

   // One APB transfer; data and error are taken at the ready edge
   task automatic apb(input apb_row_type r);
      psel   <= 1'b1;
      pwrite <= r.wr;
      paddr  <= r.addr;
      pwdata <= r.wdata;
      @(posedge pclk);
      penable <= 1'b1;
      // Only the watchdog ends a wait for the answer
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      if (!r.wr) check("read data", r.rdata, prdata);
      check("slave error", {31'h0, r.err}, {31'h0, pslverr});
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   function automatic logic pick(input int unsigned s);
      case (s)
         0: return tx_valid;
         1: return hs_mode;
         2: return suspend_n;
         default: return op_mode == OPMODE_RAW;
      endcase
   endfunction : pick

   // Bounded wait on an output level; running out counts as a mismatch
   task automatic wait_on(input int unsigned s, input logic lvl, input int unsigned lim);
      int unsigned n;
      n = 0;
      while (pick(s) !== lvl && n < lim) begin
         @(posedge pclk);
         n++;
      end
      check("awaited level", {31'h0, lvl}, {31'h0, pick(s)});
   endtask : wait_on

   task automatic final_report;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : final_report

   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
      foreach (rows[i]) apb(rows[i]);
      $display("test registers done");
      host_cmd <= 2'h1;                                       // HS host drives reset
      t0 = cyc;
      wait_on(3, 1'b1, 400);
      check_span("fs reset time", FS_RESET_CYC, FS_RESET_CYC + 6);
      wait_on(1, 1'b1, NOCH_N);
      host_cmd <= 2'h2;                                       // Brief traffic first
      @(posedge pclk);
      $display("test hs handshake done");
      host_cmd <= 2'h0;                                       // Bus goes quiet
      t0 = cyc;
      wait_on(2, 1'b0, 200);
      check_span("suspend entry", IDLE_N + SAMP_N, IDLE_N + SAMP_N + 15);
      apb('{1'b1, 32'h0, 32'h0000_0003, 32'h0, 1'b0});
      wait_on(0, 1'b1, 100);
      check_span("resume quiet", RES_N, RES_N + 10);
      wait_on(1, 1'b1, 40);
      wait_on(2, 1'b0, 200);
      $display("test suspend resume done");
      host_cmd   <= 2'h1;                                     // FS host resets a sleeper
      hs_capable <= 1'b0;
      t0 = cyc;
      wait_on(3, 1'b1, 20);
      check_span("wake to chirp", 1, 5);
      wait_on(0, 1'b1, 40);
      wait_on(0, 1'b0, 100);
      repeat (NOCH_N + 20) @(posedge pclk);
      apb('{1'b0, 32'h0000_0004, 32'h0, 32'h0000_0078, 1'b0});
      host_cmd <= 2'h0;
      repeat (6) @(posedge pclk);
      apb('{1'b0, 32'h0000_0004, 32'h0, 32'h0000_0170, 1'b0});
      $display("test fs host done");
      apb('{1'b1, 32'h0, 32'h0, 32'h0, 1'b0});
      host_cmd <= 2'h1;
      repeat (FS_RESET_CYC + 20) @(posedge pclk);
      check("op mode when disabled", {30'h0, OPMODE_NORMAL}, {30'h0, op_mode});
      apb('{1'b0, 32'h0000_0004, 32'h0, 32'h0000_0078, 1'b0});
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      check("reset outputs", 32'h0000_0062, {25'h0, xcvr_select, term_select, op_mode,
         tx_valid, suspend_n, hs_mode});
      presetn  <= 1'b1;
      host_cmd <= 2'h0;
      repeat (3) @(posedge pclk);
      apb('{1'b0, 32'h0000_0000, 32'h0, 32'h0000_0002, 1'b0});
      $display("test disable and reset done");
      final_report();
   end

   // Whole run needs a few thousand cycles; this cuts a hang short
   initial begin
      repeat (20000) @(posedge pclk);
      bad_count++;
      final_report();
   end
endmodule : bus_supervisor_tb
